// ===== design/radio_irq2_regs.vh
// Constants for the second interrupt and status register and its enable register.
// Assumes an 8-bit register port with a 7-bit address, driven by the device's host interface.
// Behaviour
// RULE1: sync-found sets on sync, clears at packet end
// RULE2: preamble-found sets, clears on sync or timeout
// RULE3: preamble-missing sets on timeout, clears itself
// RULE4: signal-strength bit follows above-threshold level
// RULE5: wake-timer bit sets on timer expiry
// RULE6: low battery latched while masked, interrupts later
// RULE7: crystal-ready sets after settling, clears at idle
// RULE8: power-on bit sets on power-on detection
// RULE9: enabled zero-to-one change pulls interrupt low
// RULE10: status read releases interrupt, clears enabled bits
// RULE11: disabled bits survive reads as plain status
// RULE12: reset contents undefined; host must not rely
// RULE13: enable register mirrors bits; lower four writable
// RULE14: interrupt low while enabled pending events remain
`ifndef RADIO_IRQ2_REGS_VH
`define RADIO_IRQ2_REGS_VH

`define ADDR_W              7
`define DATA_W              8
`define STATUS2_OFFSET      7'h04
`define ENABLE2_OFFSET      7'h06

`define BIT_SYNC_FOUND      3'h7
`define BIT_PREAMBLE_FOUND  3'h6
`define BIT_PREAMBLE_MISS   3'h5
`define BIT_SIGNAL_STRONG   3'h4
`define BIT_WAKE_TIMER      3'h3
`define BIT_LOW_BATTERY     3'h2
`define BIT_CRYSTAL_READY   3'h1
`define BIT_POWER_ON        3'h0

`define STATUS2_RESET       8'h00
`define ENABLE2_LO_RESET    4'h0
`define ENABLE2_LO_MASK     8'h0F

`endif

// ===== design/status_cell.v
// One sticky status bit with source clear and read clear.
// Assumes all inputs are synchronous to clk; rst_n is already synchronised.
`timescale 1ns/10ps
`default_nettype none
module status_cell (
  input  wire clk,
  input  wire rst_n,
  input  wire set_evt,
  input  wire src_clr,
  input  wire rd_clr,
  output reg  q
);
  reg q_d;

  // Set beats any clear in the same cycle so no event is lost
  always @* begin
    q_d = q;
    if (src_clr || rd_clr) begin
      q_d = 1'b0;
    end
    if (set_evt) begin
      q_d = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else begin
      q <= q_d;
    end
  end
endmodule
`default_nettype wire

// ===== design/radio_interrupt_status_two.v
// Second interrupt/status register, its enable register and the interrupt line.
// Assumes event inputs are one-cycle pulses from the radio's detectors, levels where noted,
// and a simple register port: one-cycle read or write strobes with address and data.
`timescale 1ns/10ps
`default_nettype none
`include "radio_irq2_regs.vh"
module radio_interrupt_status_two (
  input  wire                 sys_clk,
  input  wire                 resetn,
  input  wire [`ADDR_W-1:0]   reg_addr,
  input  wire                 reg_rd,
  input  wire                 reg_wr,
  input  wire [`DATA_W-1:0]   reg_wdata,
  output reg  [`DATA_W-1:0]   reg_rdata,
  output reg                  reg_rvalid,
  input  wire                 sync_found_evt,
  input  wire                 packet_done_evt,
  input  wire                 preamble_found_evt,
  input  wire                 sync_timeout_evt,
  input  wire                 preamble_missing_evt,
  input  wire                 rx_start_evt,
  input  wire                 signal_above_level,
  input  wire                 wake_timer_evt,
  input  wire                 low_battery_evt,
  input  wire                 battery_restored_evt,
  input  wire                 crystal_ready_evt,
  input  wire                 idle_entered_evt,
  input  wire                 power_on_evt,
  input  wire [3:0]           upper_enable,
  input  wire                 status1_pending,
  output reg                  interrupt_out_n
);
  reg                rst_meta_q;
  reg                rst_sync_q;
  wire               rst_n;
  reg  [3:0]         enable_lo_q;
  reg  [3:0]         enable_lo_d;
  wire [7:0]         enable_all;
  wire [7:0]         status_q;
  reg  [7:0]         set_vec;
  reg  [7:0]         clr_vec;
  wire [7:0]         rd_clr_vec;
  wire [7:0]         status_next;
  reg  [`DATA_W-1:0] rdata_d;
  wire               status_read;
  wire               enable_write;
  wire [7:0]         enable_all_d;
  wire [7:0]         pending_d;
  reg                irq_n_d;
  genvar             i;

  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // Reset released through two flops; assertion stays asynchronous
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // Upper enables are read-only here, steered by the preamble-detect mode elsewhere
  assign enable_all = {upper_enable, enable_lo_q}; // see RULE13

  // Writes to the status address fall through: its bits are read-only
  assign enable_write = reg_wr && hit(reg_addr, `ENABLE2_OFFSET);

  always @* begin
    enable_lo_d = enable_lo_q;
    // Upper four enables are read-only; their write bits are dropped
    if (enable_write) begin
      enable_lo_d = reg_wdata[3:0]; // see RULE13
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_lo_q <= `ENABLE2_LO_RESET;
    end else begin
      enable_lo_q <= enable_lo_d;
    end
  end

  // Per-bit set and clear terms; set wins inside each cell
  always @* begin
    set_vec = 8'h00;
    clr_vec = 8'h00;
    // Sync found stands for the rest of the packet
    if (sync_found_evt) begin
      set_vec[`BIT_SYNC_FOUND] = 1'b1; // see RULE1
    end
    if (packet_done_evt) begin
      clr_vec[`BIT_SYNC_FOUND] = 1'b1; // see RULE1
    end
    if (preamble_found_evt) begin
      set_vec[`BIT_PREAMBLE_FOUND] = 1'b1; // see RULE2
    end
    // A sync word ends the wait, so it also drops the preamble flag
    if (sync_found_evt || sync_timeout_evt) begin
      clr_vec[`BIT_PREAMBLE_FOUND] = 1'b1; // see RULE2
    end
    // Self-clearing: dropped again when the next reception starts
    if (preamble_missing_evt) begin
      set_vec[`BIT_PREAMBLE_MISS] = 1'b1; // see RULE3
    end
    if (rx_start_evt) begin
      clr_vec[`BIT_PREAMBLE_MISS] = 1'b1; // see RULE3
    end
    // Level source: set and cleared from the same comparator output
    if (signal_above_level) begin
      set_vec[`BIT_SIGNAL_STRONG] = 1'b1; // see RULE4
    end else begin
      clr_vec[`BIT_SIGNAL_STRONG] = 1'b1; // see RULE4
    end
    // Wake-timer and power-on bits are cleared only by an enabled read
    if (wake_timer_evt) begin
      set_vec[`BIT_WAKE_TIMER] = 1'b1; // see RULE5
    end
    // Latched regardless of its enable; only a read with enable set or a new battery clears
    if (low_battery_evt) begin
      set_vec[`BIT_LOW_BATTERY] = 1'b1; // see RULE6
    end
    if (battery_restored_evt) begin
      clr_vec[`BIT_LOW_BATTERY] = 1'b1;
    end
    // Crystal ready stays up until the radio returns to idle
    if (crystal_ready_evt) begin
      set_vec[`BIT_CRYSTAL_READY] = 1'b1; // see RULE7
    end
    if (idle_entered_evt) begin
      clr_vec[`BIT_CRYSTAL_READY] = 1'b1; // see RULE7
    end
    if (power_on_evt) begin
      set_vec[`BIT_POWER_ON] = 1'b1; // see RULE8
    end
  end

  assign status_read = reg_rd && hit(reg_addr, `STATUS2_OFFSET);
  // Only enabled bits are read-cleared; disabled ones stay as plain status
  assign rd_clr_vec  = {8{status_read}} & enable_all; // see RULE10 see RULE11

  // One cell per bit; each takes its own set and clear terms
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_cell
      status_cell u_cell (
        .clk     (sys_clk),
        .rst_n   (rst_n),
        .set_evt (set_vec[i]),
        .src_clr (clr_vec[i]),
        .rd_clr  (rd_clr_vec[i]),
        .q       (status_q[i])
      );
      assign status_next[i] = set_vec[i] | (status_q[i] & ~clr_vec[i] & ~rd_clr_vec[i]);
    end
  endgenerate

  // Reset value is zero only for determinism; software must not count on it
  // see RULE12

  always @* begin
    rdata_d = {`DATA_W{1'b0}};
    if (hit(reg_addr, `STATUS2_OFFSET)) begin
      rdata_d = status_q;
    end else if (hit(reg_addr, `ENABLE2_OFFSET)) begin
      rdata_d = enable_all;
    end else begin
      // Unmapped addresses read as zero
      rdata_d = {`DATA_W{1'b0}};
    end
  end

  // Data is captured only on a read, so it stands until the next one
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= {`DATA_W{1'b0}};
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // Valid follows every read strobe, mapped or not
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // Enables as they stand after this edge, so a late enable interrupts at once
  assign enable_all_d = {upper_enable, enable_lo_d};
  assign pending_d    = status_next & enable_all_d; // see RULE6

  // Level form covers a fresh rise and a masked bit that later gets enabled
  always @* begin
    irq_n_d = 1'b1;
    if (|pending_d) begin
      irq_n_d = 1'b0; // see RULE9 see RULE10
    end
    if (status1_pending) begin
      irq_n_d = 1'b0; // see RULE14
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= irq_n_d;
    end
  end
endmodule
`default_nettype wire

// ===== verif/radio_irq2_asserts.sv
// Checker on the register and interrupt ports.
// Assumes one-cycle event pulses.
`timescale 1ns/10ps
`default_nettype none
module radio_irq2_asserts (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic [6:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       sync_found_evt,
  input wire logic       packet_done_evt,
  input wire logic [3:0] upper_enable,
  input wire logic       status1_pending,
  input wire logic       interrupt_out_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic rd4 = reg_rd && reg_addr == 7'h04;
  wire logic s   = sync_found_evt;
  AST_SYNC_IRQ: assert property (s && upper_enable[3] |=> !interrupt_out_n)
    else $error("no irq");
  AST_PEND1: assert property (status1_pending |=> !interrupt_out_n)
    else $error("no irq");
  AST_SYNC_BIT: assert property (s ##1 !packet_done_evt ##1 rd4 |=> reg_rdata[7])
    else $error("bit7 low");
  AST_PKT_CLR: assert property ((packet_done_evt && !s) ##1 !s ##1 rd4 |=> !reg_rdata[7])
    else $error("bit7 high");
  AST_RVALID: assert property (reg_rd |=> reg_rvalid)
    else $error("no rvalid");
  AST_NO_RVALID: assert property (!reg_rd |=> !reg_rvalid)
    else $error("rvalid");
  AST_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("rdata moved");
  AST_UNMAP: assert property (reg_rd && reg_addr == 7'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped");
  cover property (!interrupt_out_n ##1 interrupt_out_n);
  cover property (rd4 ##1 reg_rdata[7]);
  cover property (status1_pending);
endmodule
bind radio_interrupt_status_two radio_irq2_asserts chk_u (.sys_clk, .resetn, .reg_addr,
  .reg_rd, .reg_rdata, .reg_rvalid, .sync_found_evt, .packet_done_evt, .upper_enable,
  .status1_pending, .interrupt_out_n);
`default_nettype wire

// ===== verif/irq_host_model.sv
// Host model: strobe reads and writes of the register port.
// Assumes calls come after reset release.
`timescale 1ns/10ps
`default_nettype none
module irq_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output var  logic [6:0] reg_addr,
  output var  logic       reg_rd,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata
);
  initial {reg_addr, reg_rd, reg_wr, reg_wdata} = 17'h00000;
  task automatic wr(input logic [6:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    #1;
  endtask
  // Idle address shows junk so a stale decode is caught
  task automatic rd(input logic [6:0] a, output logic [7:0] x, output logic v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // Answer lands at this edge; valid lasts one cycle, data stands until the next read; take it once settled
    #1;
    x = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
`default_nettype wire

// ===== verif/radio_interrupt_status_two_tb_top.sv
// Testbench: event pulses and status reads with expected values.
// Assumes the host model owns the register port.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected %0t %h %h", $time, a, e); end end
module radio_interrupt_status_two_tb_top;
  logic       sys_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [4:0] cl = 5'h00;
  logic [3:0] upper_enable = 4'h0;
  logic       status1_pending = 1'b0;
  logic [6:0] reg_addr;
  logic       reg_rd, reg_wr, reg_rvalid, irq_n, v;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [7:0] sm [5] = '{8'h80, 8'h20, 8'h04, 8'h02, 8'h40};
  int         err_total = 0;
  int         checks = 0;
  always #4 sys_clk = ~sys_clk;
  radio_interrupt_status_two dut_u (.sys_clk, .resetn, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .sync_found_evt(ev[7]), .preamble_found_evt(ev[6]),
    .preamble_missing_evt(ev[5]), .signal_above_level(ev[4]), .wake_timer_evt(ev[3]),
    .low_battery_evt(ev[2]), .crystal_ready_evt(ev[1]), .power_on_evt(ev[0]),
    .packet_done_evt(cl[0]), .rx_start_evt(cl[1]), .battery_restored_evt(cl[2]),
    .idle_entered_evt(cl[3]), .sync_timeout_evt(cl[4]), .upper_enable, .status1_pending,
    .interrupt_out_n(irq_n));
  irq_host_model host_u (.sys_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_rd, .reg_wr,
    .reg_wdata);
  task automatic pulse(input logic [7:0] s, input logic [4:0] c);
    @(posedge sys_clk);
    ev <= s;
    cl <= c;
    @(posedge sys_clk);
    ev <= 8'h00;
    cl <= 5'h00;
    #1;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e, input logic q);
    host_u.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
    `CHK(irq_n, q)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    host_u.wr(7'h06, 8'h00);
    pulse(8'h04, 5'h00);
    `CHK(irq_n, 1'b1)
    host_u.wr(7'h06, 8'hFF);
    `CHK(irq_n, 1'b0)
    rdc(7'h06, 8'h0F, 1'b0);
    rdc(7'h04, 8'h04, 1'b1);
    rdc(7'h04, 8'h00, 1'b1);
    $display("late enable test done");
    host_u.wr(7'h06, 8'h00);
    pulse(8'h40, 5'h00);
    pulse(8'h80, 5'h00);
    rdc(7'h04, 8'h80, 1'b1);
    rdc(7'h04, 8'h80, 1'b1);
    for (int j = 0; j < 5; j++) begin
      pulse(sm[j], 5'h00);
      rdc(7'h04, sm[j], 1'b1);
      pulse(8'h00, 5'h01 << j);
      rdc(7'h04, 8'h00, 1'b1);
    end
    $display("source clear test done");
    @(posedge sys_clk);
    upper_enable <= 4'hF;
    host_u.wr(7'h06, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      if (i != 4) begin
        pulse(8'h01 << i, 5'h00);
        `CHK(irq_n, 1'b0)
        rdc(7'h04, 8'h01 << i, 1'b1);
      end
    end
    @(posedge sys_clk);
    ev[4] <= 1'b1;
    rdc(7'h04, 8'h10, 1'b0);
    @(posedge sys_clk);
    ev[4] <= 1'b0;
    rdc(7'h04, 8'h00, 1'b1);
    @(posedge sys_clk);
    status1_pending <= 1'b1;
    rdc(7'h04, 8'h00, 1'b0);
    @(posedge sys_clk);
    status1_pending <= 1'b0;
    rdc(7'h10, 8'h00, 1'b1);
    $display("enabled source test done");
    finish_test;
  end
  initial begin
    #20000;
    err_total++;
    finish_test;
  end
endmodule
`default_nettype wire
